// ---- qshp_pkg.sv ----
// package: codes, formats and timing shared by both ends of the quad serial port
// Contract
// - select low frames every transfer
// - host drives clock, idle high
// - device samples on clock rising edge
// - commands one line, pixels four lines
// - instruction 02h means command write
// - instruction 03h means command read
// - instruction 12h or 32h: quad pixels
// - instruction byte then address and parameters
// - address is zero, command, zero
// - many parameters allowed in one frame
// - pixel writes target 2C00 or 3C00
// - short pixel address 2C or 3C
// - 32h long address, 12h short address
// - unpack six colour formats, optional swap
// - read bits sampled on rising edge
// - read spans select low to high
// - read address uses same zero padding
// - break mid-byte drops partial byte
// - pause at byte boundary resumes sequence; code resumes only mid-header, else restarts at instruction
package qshp_pkg;
  localparam logic [7:0] PI_CMD_WR = 8'h02;
  localparam logic [7:0] PI_CMD_RD = 8'h03;
  localparam logic [7:0] PI_PIX_SHORT = 8'h12;
  localparam logic [7:0] PI_PIX_LONG = 8'h32;
  localparam logic [7:0] CMD_PIX_START = 8'h2c;
  localparam logic [7:0] CMD_PIX_CONT = 8'h3c;
  localparam logic [7:0] ADDR_PAD = 8'h00;
  // pixel format codes
  localparam logic [2:0] FMT_GREY = 3'h1;
  localparam logic [2:0] FMT_332 = 3'h2;
  localparam logic [2:0] FMT_111 = 3'h3;
  localparam logic [2:0] FMT_565 = 3'h5;
  localparam logic [2:0] FMT_666 = 3'h6;
  localparam logic [2:0] FMT_888 = 3'h7;
  // last bit slot of a byte on one line and on four lines
  localparam logic [2:0] SINGLE_LAST = 3'h7;
  localparam logic [2:0] QUAD_LAST = 3'h1;
  // host link clock half period, least time rounded up
  localparam int MCLK_PERIOD_NS = 50;
  localparam int HOST_HALF_NS = 200;
  localparam int HOST_HALF_CYC = (HOST_HALF_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  // kinds of byte handed from the link domain to the user side
  typedef enum logic [1:0] {
    EV_CMD = 2'b00,
    EV_PARAM = 2'b01,
    EV_PIX = 2'b10
  } qshp_ev_e;
endpackage : qshp_pkg

// ---- qshp_if.sv ----
// interface: the quad serial link between host and device
`timescale 1ns/1ps
`default_nettype none
interface qshp_if;
  logic select_line_n;
  logic link_clk;
  logic host_io0_o;
  logic host_io0_oe;
  logic dev_io0_o;
  logic dev_io0_oe;
  logic data_command_line;
  logic quad_data_line2;
  logic quad_data_line3;
  wire serial_io_line0;
  // shared line resolved from the enables, pulled high when nobody drives
  assign serial_io_line0 = host_io0_oe ? host_io0_o : (dev_io0_oe ? dev_io0_o : 1'b1);
  modport host (
    output select_line_n, link_clk, host_io0_o, host_io0_oe,
    output data_command_line, quad_data_line2, quad_data_line3,
    input serial_io_line0
  );
  modport dev (
    input select_line_n, link_clk, serial_io_line0,
    input data_command_line, quad_data_line2, quad_data_line3,
    output dev_io0_o, dev_io0_oe
  );
endinterface : qshp_if
`default_nettype wire

// ---- qshp_dev.sv ----
// module: device end of the quad serial port, link decode and pixel unpack
`timescale 1ns/1ps
`default_nettype none
module qshp_dev
  import qshp_pkg::*;
#(
  parameter int RD_BYTES = 4
)
(
  input wire logic mclk,
  input wire logic rst,
  qshp_if.dev link,
  input wire logic [2:0] pix_format,
  input wire logic halfword_swap_16bit,
  input wire logic [RD_BYTES*8-1:0] rd_data,
  input wire logic rd_load,
  output logic cmd_valid,
  output logic [7:0] cmd_code,
  output logic cmd_is_read,
  output logic param_valid,
  output logic [7:0] command_parameter,
  output logic pix_valid,
  output logic [23:0] pix_rgb,
  output logic pix_start
);
  initial begin
    if (RD_BYTES < 1 || RD_BYTES > 16) $error("qshp_dev: RD_BYTES must be 1..16");
  end

  typedef enum logic [2:0] {
    RX_PI = 3'b000,
    RX_AD0 = 3'b001,
    RX_AD1 = 3'b010,
    RX_AD2 = 3'b011,
    RX_PARAM = 3'b100,
    RX_READ = 3'b101,
    RX_PIX = 3'b110,
    RX_SKIP = 3'b111
  } qshp_rx_e;

  // ----------------------------------------------------------------
  // link domain: byte assembly
  // ----------------------------------------------------------------
  logic [2:0] bit_r;
  logic fresh_r;
  logic [6:0] sh_r;
  qshp_rx_e st_r;
  qshp_rx_e st_nxt;
  logic [7:0] pi_r;
  logic [3:0] rd_idx_r;
  logic out_r;
  logic oe_r;
  logic ev_tog_r;
  qshp_ev_e ev_kind_r;
  logic [7:0] ev_byte_r;
  logic [RD_BYTES*8-1:0] rd_hold_r;

  // a new frame restarts at the instruction unless a header was paused
  wire in_hdr = (st_r == RX_AD0) || (st_r == RX_AD1) || (st_r == RX_AD2);
  wire qshp_rx_e st_eff = (fresh_r && !in_hdr) ? RX_PI : st_r;
  wire quad = (st_eff == RX_PIX);
  wire [3:0] nib = {link.quad_data_line3, link.quad_data_line2,
                    link.data_command_line, link.serial_io_line0};
  wire byte_done = quad ? (bit_r == QUAD_LAST) : (bit_r == SINGLE_LAST);
  wire [7:0] byte_val = quad ? {sh_r[3:0], nib} : {sh_r, link.serial_io_line0};
  wire pix_cmd_ok = (byte_val == CMD_PIX_START) || (byte_val == CMD_PIX_CONT);
  wire [7:0] rd_byte = rd_hold_r[(RD_BYTES - 1 - 32'(rd_idx_r)) * 8 +: 8];

  // bit slot counter; select high clears it so a broken byte is dropped
  always_ff @(posedge link.link_clk or posedge link.select_line_n)
  begin
    if (link.select_line_n)
      bit_r <= 3'h0;
    else
      bit_r <= byte_done ? 3'h0 : bit_r + 3'h1;
  end

  // marks the first clock after select falls
  always_ff @(posedge link.link_clk or posedge link.select_line_n)
  begin
    if (link.select_line_n)
      fresh_r <= 1'b1;
    else
      fresh_r <= 1'b0;
  end

  // shift register, rising-edge capture
  always_ff @(posedge link.link_clk)
  begin
    sh_r <= byte_val[6:0];
  end

  // sequence decode on each completed byte
  always_comb
  begin
    st_nxt = st_eff;
    if (byte_done)
    begin
      case (st_eff)
        RX_PI:
        begin
          case (byte_val)
            PI_CMD_WR, PI_CMD_RD, PI_PIX_LONG: st_nxt = RX_AD0;
            PI_PIX_SHORT: st_nxt = RX_AD1;
            default: st_nxt = RX_SKIP;
          endcase
        end
        RX_AD0: st_nxt = RX_AD1;
        RX_AD1:
        begin
          if (pi_r == PI_PIX_SHORT)
            st_nxt = pix_cmd_ok ? RX_PIX : RX_SKIP;
          else if (pi_r == PI_PIX_LONG && !pix_cmd_ok)
            st_nxt = RX_SKIP;
          else
            st_nxt = RX_AD2;
        end
        RX_AD2:
        begin
          case (pi_r)
            PI_CMD_WR: st_nxt = RX_PARAM;
            PI_CMD_RD: st_nxt = RX_READ;
            default: st_nxt = RX_PIX;
          endcase
        end
        default: st_nxt = st_eff;
      endcase
    end
  end

  // sequence state; held across select high so a pause inside the address header resumes
  always_ff @(posedge link.link_clk or posedge rst)
  begin
    if (rst)
      st_r <= RX_PI;
    else
      st_r <= st_nxt;
  end

  always_ff @(posedge link.link_clk)
  begin
    if (byte_done && st_eff == RX_PI)
      pi_r <= byte_val;
  end

  // read byte index, restarted when the read phase begins
  always_ff @(posedge link.link_clk)
  begin
    if (st_eff != RX_READ)
      rd_idx_r <= 4'h0;
    else if (byte_done)
      rd_idx_r <= (32'(rd_idx_r) == RD_BYTES - 1) ? 4'h0 : rd_idx_r + 4'h1;
  end

  // read data changes on the falling edge so the host can take it rising
  always_ff @(negedge link.link_clk)
  begin
    out_r <= rd_byte[3'h7 - bit_r];
  end

  assign link.dev_io0_o = out_r;
  // drive starts on a falling edge, after the host has let go of line0
  always_ff @(negedge link.link_clk or posedge link.select_line_n)
  begin
    if (link.select_line_n)
      oe_r <= 1'b0;
    else
      oe_r <= (st_r == RX_READ) && !fresh_r;
  end

  assign link.dev_io0_oe = oe_r && !link.select_line_n;

  // event hand-off: data and toggle update on the same edge, then the data holds
  always_ff @(posedge link.link_clk or posedge rst)
  begin
    if (rst)
      ev_tog_r <= 1'b0;
    else if (byte_done && (st_eff == RX_AD1 || st_eff == RX_PARAM || st_eff == RX_PIX))
      ev_tog_r <= ~ev_tog_r;
  end

  always_ff @(posedge link.link_clk)
  begin
    if (byte_done)
    begin
      ev_byte_r <= byte_val;
      ev_kind_r <= (st_eff == RX_AD1) ? EV_CMD : ((st_eff == RX_PIX) ? EV_PIX : EV_PARAM);
    end
  end

  // ----------------------------------------------------------------
  // user domain: crossing and pixel unpack
  // ----------------------------------------------------------------
  logic tog_s1_r;
  logic tog_s2_r;
  logic tog_s3_r;
  logic [7:0] b0_r;
  logic [7:0] b1_r;
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;

  // read reply is loaded ahead of a frame and must stay put during it
  always_ff @(posedge mclk)
  begin
    if (rst)
      rd_hold_r <= '0;
    else if (rd_load)
      rd_hold_r <= rd_data;
  end

  // toggle synchroniser; the second and third stages feed the edge detect
  always_ff @(posedge mclk)
  begin
    tog_s1_r <= ev_tog_r;
    tog_s2_r <= tog_s1_r;
    tog_s3_r <= tog_s2_r;
  end

  wire ev = tog_s2_r ^ tog_s3_r;
  wire ev_pix = ev && ev_kind_r == EV_PIX;
  wire [1:0] bpp = (pix_format == FMT_888 || pix_format == FMT_666) ? 2'h3 :
                   (pix_format == FMT_565) ? 2'h2 : 2'h1;
  wire pix_done = ev_pix && (cnt_r + 2'h1 == bpp);
  wire [15:0] hw = halfword_swap_16bit ? {ev_byte_r, b0_r} : {b0_r, ev_byte_r};

  // colour expansion of the completed pixel
  logic [23:0] rgb;
  always_comb
  begin
    case (pix_format)
      FMT_888: rgb = {b0_r, b1_r, ev_byte_r};
      FMT_666: rgb = {b0_r[7:2], 2'h0, b1_r[7:2], 2'h0, ev_byte_r[7:2], 2'h0};
      FMT_565: rgb = {hw[15:11], 3'h0, hw[10:5], 2'h0, hw[4:0], 3'h0};
      FMT_332: rgb = {ev_byte_r[7:5], 5'h0, ev_byte_r[4:2], 5'h0, ev_byte_r[1:0], 6'h0};
      FMT_111: rgb = {{8{ev_byte_r[2]}}, {8{ev_byte_r[1]}}, {8{ev_byte_r[0]}}};
      FMT_GREY: rgb = {ev_byte_r, ev_byte_r, ev_byte_r};
      default: rgb = 24'h0;
    endcase
  end

  assign cnt_nxt = (pix_done || (ev && ev_kind_r == EV_CMD)) ? 2'h0 : cnt_r + 2'h1;

  // byte gathering per pixel; a command byte realigns the count
  always_ff @(posedge mclk)
  begin
    if (rst)
      cnt_r <= 2'h0;
    else if (ev_pix || (ev && ev_kind_r == EV_CMD))
      cnt_r <= cnt_nxt;
  end

  always_ff @(posedge mclk)
  begin
    if (ev_pix && cnt_r == 2'h0)
      b0_r <= ev_byte_r;
    if (ev_pix && cnt_r == 2'h1)
      b1_r <= ev_byte_r;
  end

  // registered user outputs
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      cmd_valid <= 1'b0;
      cmd_code <= 8'h0;
      cmd_is_read <= 1'b0;
      param_valid <= 1'b0;
      command_parameter <= 8'h0;
      pix_valid <= 1'b0;
      pix_rgb <= 24'h0;
      pix_start <= 1'b0;
    end
    else
    begin
      cmd_valid <= ev && ev_kind_r == EV_CMD;
      param_valid <= ev && ev_kind_r == EV_PARAM;
      pix_valid <= pix_done;
      if (ev && ev_kind_r == EV_CMD)
      begin
        cmd_code <= ev_byte_r;
        cmd_is_read <= (pi_r == PI_CMD_RD);
        pix_start <= (ev_byte_r == CMD_PIX_START);
      end
      if (ev && ev_kind_r == EV_PARAM)
        command_parameter <= ev_byte_r;
      if (pix_done)
        pix_rgb <= rgb;
    end
  end
endmodule : qshp_dev
`default_nettype wire

// ---- qshp_host.sv ----
// module: host end of the quad serial port, frames requests onto the link
`timescale 1ns/1ps
`default_nettype none
module qshp_host
  import qshp_pkg::*;
#(
  parameter int HALF = HOST_HALF_CYC
)
(
  input wire logic mclk,
  input wire logic rst,
  qshp_if.host link,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [7:0] req_pi,
  input wire logic [7:0] req_cmd,
  input wire logic [15:0] req_len,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] tx_data,
  output logic rx_valid,
  output logic [7:0] rx_data
);
  initial begin
    if (HALF < 3 || HALF > 255) $error("qshp_host: HALF must be 3..255");
  end

  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_SEL = 3'b001,
    H_NEXT = 3'b010,
    H_LOW = 3'b011,
    H_HIGH = 3'b100,
    H_END = 3'b101
  } qshp_h_e;

  qshp_h_e st_r;
  logic [7:0] div_r;
  logic [7:0] sh_r;
  logic [2:0] bit_r;
  logic [31:0] hdr_r;
  logic [2:0] hdr_left_r;
  logic [15:0] pay_left_r;
  logic [7:0] pi_r;
  logic quad_r;
  logic rd_r;
  logic sclk_r;
  logic sel_n_r;
  logic io_s1_r;
  logic io_s2_r;

  wire tick = (div_r == 8'(HALF - 1));
  wire is_rd = (pi_r == PI_CMD_RD);
  wire byte_last = quad_r ? (bit_r == QUAD_LAST) : (bit_r == SINGLE_LAST);
  wire pay_wait = (hdr_left_r == 3'h0) && (pay_left_r != 16'h0) && !is_rd && !tx_valid;

  assign req_ready = (st_r == H_IDLE);
  assign tx_ready = (st_r == H_NEXT) && (hdr_left_r == 3'h0) && (pay_left_r != 16'h0) && !is_rd;

  // link pins: data comes straight from the shift register flops
  assign link.select_line_n = sel_n_r;
  assign link.link_clk = sclk_r;
  assign link.host_io0_o = quad_r ? sh_r[4] : sh_r[7];
  assign link.host_io0_oe = !sel_n_r && !rd_r;
  assign link.data_command_line = quad_r & sh_r[5];
  assign link.quad_data_line2 = quad_r & sh_r[6];
  assign link.quad_data_line3 = quad_r & sh_r[7];

  // two-flop capture of the returned line
  always_ff @(posedge mclk)
  begin
    io_s1_r <= link.serial_io_line0;
    io_s2_r <= io_s1_r;
  end

  // half-period divider, restarted on every phase change
  always_ff @(posedge mclk)
  begin
    if (rst || st_r == H_IDLE || st_r == H_NEXT)
      div_r <= 8'h0;
    else
      div_r <= tick ? 8'h0 : div_r + 8'h1;
  end

  // frame sequencer: instruction, address (zero padded except for 12h), then payload bytes
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      st_r <= H_IDLE;
      sclk_r <= 1'b1;
      sel_n_r <= 1'b1;
      quad_r <= 1'b0;
      rd_r <= 1'b0;
      rx_valid <= 1'b0;
      rx_data <= 8'h0;
      sh_r <= 8'h0;
      bit_r <= 3'h0;
      hdr_r <= 32'h0;
      hdr_left_r <= 3'h0;
      pay_left_r <= 16'h0;
      pi_r <= 8'h0;
    end
    else
    begin
      rx_valid <= 1'b0;
      case (st_r)
        H_IDLE:
        begin
          if (req_valid)
          begin
            pi_r <= req_pi;
            pay_left_r <= req_len;
            sel_n_r <= 1'b0;
            if (req_pi == PI_PIX_SHORT)
            begin
              hdr_r <= {req_pi, req_cmd, 16'h0};
              hdr_left_r <= 3'h2;
            end
            else
            begin
              hdr_r <= {req_pi, ADDR_PAD, req_cmd, ADDR_PAD};
              hdr_left_r <= 3'h4;
            end
            st_r <= H_SEL;
          end
        end
        H_SEL:
          if (tick)
            st_r <= H_NEXT;
        H_NEXT:
        begin
          bit_r <= 3'h0;
          if (hdr_left_r != 3'h0)
          begin
            sh_r <= hdr_r[31:24];
            hdr_r <= {hdr_r[23:0], 8'h0};
            hdr_left_r <= hdr_left_r - 3'h1;
            quad_r <= 1'b0;
            sclk_r <= 1'b0;
            st_r <= H_LOW;
          end
          else if (pay_left_r == 16'h0)
            st_r <= H_END;
          else if (!pay_wait)
          begin
            sh_r <= is_rd ? 8'h0 : tx_data;
            quad_r <= (pi_r == PI_PIX_SHORT) || (pi_r == PI_PIX_LONG);
            rd_r <= is_rd;
            pay_left_r <= pay_left_r - 16'h1;
            sclk_r <= 1'b0;
            st_r <= H_LOW;
          end
        end
        H_LOW:
        begin
          sclk_r <= 1'b0;
          if (tick)
          begin
            sclk_r <= 1'b1;
            st_r <= H_HIGH;
            if (rd_r)
              sh_r <= {sh_r[6:0], io_s2_r};
          end
        end
        H_HIGH:
        begin
          if (tick)
          begin
            bit_r <= bit_r + 3'h1;
            if (byte_last)
            begin
              rx_valid <= rd_r;
              rx_data <= sh_r;
              st_r <= H_NEXT;
            end
            else
            begin
              // data moves only with the falling clock, never while it is high
              sclk_r <= 1'b0;
              if (!rd_r)
                sh_r <= quad_r ? {sh_r[3:0], 4'h0} : {sh_r[6:0], 1'b0};
              st_r <= H_LOW;
            end
          end
        end
        H_END:
        begin
          if (tick)
          begin
            sel_n_r <= 1'b1;
            rd_r <= 1'b0;
            quad_r <= 1'b0;
            st_r <= H_IDLE;
          end
        end
        default: st_r <= H_IDLE;
      endcase
    end
  end
endmodule : qshp_host
`default_nettype wire

// ---- qshp_sva.sv ----
// checker: clock shape, framing and line ownership on the host-device link
`timescale 1ns/1ps
`default_nettype none
module qshp_chk
#(
  parameter int HALF = 4
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic select_line_n,
  input wire logic link_clk,
  input wire logic host_io0_o,
  input wire logic host_io0_oe,
  input wire logic dev_io0_o,
  input wire logic dev_io0_oe,
  input wire logic data_command_line,
  input wire logic quad_data_line2,
  input wire logic quad_data_line3
);
  // ------------------------------------------------------------
  // run-length counters
  // ------------------------------------------------------------
  // saturating so that a long idle never wraps into a false short pulse
  logic [7:0] lo_cnt_r, hi_cnt_r, sel_cnt_r, lo_cnt_nxt, hi_cnt_nxt, sel_cnt_nxt;
  logic [3:0] quad_w;
  assign lo_cnt_nxt = link_clk ? 8'h00 : lo_cnt_r + {7'h00, lo_cnt_r != 8'hff};
  assign hi_cnt_nxt = !link_clk ? 8'h00 : hi_cnt_r + {7'h00, hi_cnt_r != 8'hff};
  assign sel_cnt_nxt = select_line_n ? 8'h00 : sel_cnt_r + {7'h00, sel_cnt_r != 8'hff};
  assign quad_w = {quad_data_line3, quad_data_line2, data_command_line, host_io0_o};
  // counters clear while reset holds
  always_ff @(posedge mclk)
  begin
    lo_cnt_r <= rst ? 8'h00 : lo_cnt_nxt;
    hi_cnt_r <= rst ? 8'h00 : hi_cnt_nxt;
    sel_cnt_r <= rst ? 8'h00 : sel_cnt_nxt;
  end
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  sequence s_clk_fall;
    link_clk ##1 !link_clk;
  endsequence
  sequence s_high_settled;
    !select_line_n && link_clk ##1 !select_line_n && link_clk;
  endsequence
  property p_clk_idle;
    select_line_n |-> link_clk;
  endproperty
  property p_fall_framed;
    s_clk_fall |-> !select_line_n && sel_cnt_r >= 8'(HALF - 1);
  endproperty
  property p_low_width;
    $rose(link_clk) |-> lo_cnt_r == 8'(HALF);
  endproperty
  property p_high_width;
    s_clk_fall |-> hi_cnt_r >= 8'(HALF);
  endproperty
  property p_host_stable;
    s_high_settled ##0 (host_io0_oe && $past(host_io0_oe)) |-> $stable(quad_w);
  endproperty
  property p_dev_stable;
    s_high_settled ##0 (dev_io0_oe && $past(dev_io0_oe)) |-> $stable(dev_io0_o);
  endproperty
  property p_one_driver;
    !(host_io0_oe && dev_io0_oe);
  endproperty
  property p_dev_framed;
    $rose(dev_io0_oe) |-> !select_line_n;
  endproperty
  property p_tail;
    $rose(select_line_n) |-> link_clk && hi_cnt_r >= 8'(HALF - 1);
  endproperty
  a_clk_idle: assert property (p_clk_idle)
    else $error("link clock low outside a frame");
  a_fall_framed: assert property (p_fall_framed)
    else $error("clock fell without select set up");
  a_low_width: assert property (p_low_width)
    else $error("clock low phase has wrong length");
  a_high_width: assert property (p_high_width)
    else $error("clock high phase too short");
  a_host_stable: assert property (p_host_stable)
    else $error("host data moved while clock high");
  a_dev_stable: assert property (p_dev_stable)
    else $error("device data moved while clock high");
  a_one_driver: assert property (p_one_driver)
    else $error("both ends drive line0");
  a_dev_framed: assert property (p_dev_framed)
    else $error("device drove line0 outside a frame");
  a_tail: assert property (p_tail)
    else $error("frame closed too early after last bit");
endmodule : qshp_chk
`default_nettype wire

// ---- tb_quad_serial_host_port.sv ----
// testbench: host and device joined over the link, plus a second device on a hand-driven link
`timescale 1ns/1ps
`default_nettype none
module tb_quad_serial_host_port
  import qshp_pkg::*;
();
  localparam int HALF_C = 4;
  localparam int RDB = 4;
  logic mclk = 1'b0, rst = 1'b0, req_valid = 1'b0, tx_valid = 1'b0, swap = 1'b0, rd_load = 1'b0;
  logic req_ready, tx_ready, rx_valid, cmd_valid, cmd_rd, param_valid, pix_valid, pix_start;
  logic cmd_valid_b, param_valid_b;
  logic [7:0] req_pi = 8'h00, req_cmd = 8'h00, tx_data = 8'h00, rx_data, cmd_code, cmd_param;
  logic [7:0] cmd_code_b, param_b, cm;
  logic [15:0] req_len = 16'h0000;
  logic [2:0] pix_format = FMT_888;
  logic [RDB*8-1:0] rd_data = {RDB{8'h00}};
  logic [23:0] pix_rgb;
  logic [8:0] cq[$];
  logic [7:0] pq[$], rq[$], cq_b[$], pq_b[$], pay[16];
  logic [24:0] xq[$];
  logic [2:0] fmt_t[7] = '{FMT_888, FMT_666, FMT_565, FMT_565, FMT_332, FMT_111, FMT_GREY};
  int bpp_t[7] = '{3, 3, 2, 2, 1, 1, 1};
  int num_errors = 0, n_tests = 0, i, k, n, b;
  qshp_if u_qshp_if ();
  qshp_if u_qshp_if_b ();
  qshp_host #(.HALF(HALF_C)) u_qshp_host (.mclk(mclk), .rst(rst), .link(u_qshp_if.host),
    .req_valid(req_valid), .req_ready(req_ready), .req_pi(req_pi), .req_cmd(req_cmd),
    .req_len(req_len), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .rx_valid(rx_valid), .rx_data(rx_data));
  qshp_dev #(.RD_BYTES(RDB)) u_qshp_dev (.mclk(mclk), .rst(rst), .link(u_qshp_if.dev),
    .pix_format(pix_format), .halfword_swap_16bit(swap), .rd_data(rd_data), .rd_load(rd_load),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_is_read(cmd_rd), .param_valid(param_valid),
    .command_parameter(cmd_param), .pix_valid(pix_valid), .pix_rgb(pix_rgb), .pix_start(pix_start));
  qshp_dev #(.RD_BYTES(RDB)) u_qshp_dev_b (.mclk(mclk), .rst(rst), .link(u_qshp_if_b.dev),
    .pix_format(pix_format), .halfword_swap_16bit(swap), .rd_data(rd_data), .rd_load(rd_load),
    .cmd_valid(cmd_valid_b), .cmd_code(cmd_code_b), .cmd_is_read(), .param_valid(param_valid_b),
    .command_parameter(param_b), .pix_valid(), .pix_rgb(), .pix_start());
  qshp_chk #(.HALF(HALF_C)) u_qshp_chk (.mclk(mclk), .rst(rst),
    .select_line_n(u_qshp_if.select_line_n), .link_clk(u_qshp_if.link_clk),
    .host_io0_o(u_qshp_if.host_io0_o), .host_io0_oe(u_qshp_if.host_io0_oe),
    .dev_io0_o(u_qshp_if.dev_io0_o), .dev_io0_oe(u_qshp_if.dev_io0_oe),
    .data_command_line(u_qshp_if.data_command_line),
    .quad_data_line2(u_qshp_if.quad_data_line2), .quad_data_line3(u_qshp_if.quad_data_line3));
  // ------------------------------------------------------------
  // clock, output capture and helpers
  // ------------------------------------------------------------
  always #25 mclk = ~mclk;
  // pulses stand one cycle, so take them mid-cycle away from the launching edge
  always @(negedge mclk)
  begin
    if (cmd_valid === 1'b1) cq.push_back({cmd_rd, cmd_code});
    if (param_valid === 1'b1) pq.push_back(cmd_param);
    if (pix_valid === 1'b1) xq.push_back({pix_start, pix_rgb});
    if (rx_valid === 1'b1) rq.push_back(rx_data);
    if (cmd_valid_b === 1'b1) cq_b.push_back(cmd_code_b);
    if (param_valid_b === 1'b1) pq_b.push_back(param_b);
  end
  task automatic chk(input logic [24:0] seen, input logic [24:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim
  // colours widen by zero fill, 111 by bit copy; grey copies one byte to all three channels
  function automatic logic [23:0] exp_pix(input logic [2:0] f, input logic sw,
                                          input logic [7:0] x, y, z);
    logic [15:0] h;
    h = sw ? {y, x} : {x, y};
    case (f)
      FMT_888: return {x, y, z};
      FMT_666: return {x[7:2], 2'h0, y[7:2], 2'h0, z[7:2], 2'h0};
      FMT_565: return {h[15:11], 3'h0, h[10:5], 2'h0, h[4:0], 3'h0};
      FMT_332: return {x[7:5], 5'h00, x[4:2], 5'h00, x[1:0], 6'h00};
      FMT_111: return {{8{x[2]}}, {8{x[1]}}, {8{x[0]}}};
      default: return {x, x, x};
    endcase
  endfunction : exp_pix
  // one host request; payload bytes come from pay, with random stalls between them
  task automatic frame(input logic [7:0] ins, input logic [7:0] cmd, input int len);
    int w;
    @(posedge mclk);
    #2;
    req_valid = 1'b1;
    req_pi = ins;
    req_cmd = cmd;
    req_len = 16'(len);
    for (w = 0; w < 9000 && req_ready !== 1'b1; w++) @(negedge mclk);
    @(posedge mclk);
    #2;
    req_valid = 1'b0;
    for (int j = 0; j < len && ins != PI_CMD_RD; j++)
    begin
      // at least one edge passes between lowering and raising valid
      repeat (($urandom_range(3) == 0) ? 40 : 1) @(posedge mclk);
      #2;
      tx_valid = 1'b1;
      tx_data = pay[j];
      for (w = 0; w < 9000 && tx_ready !== 1'b1; w++) @(negedge mclk);
      @(posedge mclk);
      #2;
      tx_valid = 1'b0;
    end
    repeat (2) @(negedge mclk);
    for (w = 0; w < 90000 && u_qshp_if.select_line_n !== 1'b1; w++) @(negedge mclk);
    repeat (12) @(posedge mclk);
  endtask : frame
  task automatic run(input logic [7:0] ins, input logic [7:0] cmd, input int len);
    frame(ins, cmd, len);
    chk(25'(cq.size()), 25'h1);
    chk(25'(cq.pop_front()), {16'h0000, ins == PI_CMD_RD, cmd});
    for (int j = 0; j < len && ins == PI_CMD_WR; j++) chk(25'(pq.pop_front()), 25'(pay[j]));
    for (int j = 0; j < len && ins == PI_CMD_RD; j++)
      chk(25'(rq.pop_front()), 25'(rd_data[8*(RDB-1-j%RDB) +: 8]));
    chk(25'(pq.size() + rq.size()), 25'h0);
  endtask : run
  // the hand-driven link runs its own 125 ns clock, only inside frames
  task automatic bb_sel(input logic lvl);
    #200;
    u_qshp_if_b.select_line_n = lvl;
    u_qshp_if_b.host_io0_oe = !lvl;
    #200;
  endtask : bb_sel
  task automatic bb_bits(input logic [7:0] v, input int nb);
    for (int j = 7; j > 7 - nb; j--)
    begin
      u_qshp_if_b.link_clk = 1'b0;
      u_qshp_if_b.host_io0_o = v[j];
      #62.5;
      u_qshp_if_b.link_clk = 1'b1;
      #62.5;
    end
  endtask : bb_bits
  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial
  begin
    u_qshp_if_b.select_line_n = 1'b0;
    u_qshp_if_b.link_clk = 1'b1;
    u_qshp_if_b.host_io0_o = 1'b0;
    u_qshp_if_b.host_io0_oe = 1'b0;
    u_qshp_if_b.data_command_line = 1'b0;
    u_qshp_if_b.quad_data_line2 = 1'b0;
    u_qshp_if_b.quad_data_line3 = 1'b0;
    void'($urandom(32'h0c9ffd31));
    // real edges on reset and select so the link-side async resets take hold
    #1;
    rst = 1'b1;
    u_qshp_if_b.select_line_n = 1'b1;
    repeat (12) @(posedge mclk);
    #2;
    rst = 1'b0;
    for (k = 0; k < 6; k++)
    begin
      n = (k == 0) ? 0 : (k == 1) ? 4 : $urandom_range(3, 1);
      for (i = 0; i < n; i++) pay[i] = 8'($urandom);
      run(PI_CMD_WR, 8'($urandom), n);
    end
    $display("command write test done");
    frame(8'h55, 8'h2a, 2);
    chk(25'(cq.size() + pq.size()), 25'h0);
    $display("unknown instruction test done");
    @(posedge mclk);
    #2;
    for (i = 0; i < RDB; i++) rd_data[8*i +: 8] = 8'($urandom);
    rd_load = 1'b1;
    @(posedge mclk);
    #2;
    rd_load = 1'b0;
    run(PI_CMD_RD, 8'($urandom), RDB + 2);
    $display("command read test done");
    for (k = 0; k < 7; k++)
    begin
      #2;
      pix_format = fmt_t[k];
      swap = (k == 3);
      for (i = 0; i < 6; i++) pay[i] = 8'($urandom);
      cm = ((k / 2) % 2) ? CMD_PIX_CONT : CMD_PIX_START;
      run((k % 2) ? PI_PIX_SHORT : PI_PIX_LONG, cm, 2 * bpp_t[k]);
      chk(25'(xq.size()), 25'h2);
      for (i = 0; i < 2; i++)
      begin
        b = i * bpp_t[k];
        chk(xq.pop_front(), {cm == CMD_PIX_START,
            exp_pix(fmt_t[k], swap, pay[b], pay[b+1], pay[b+2])});
      end
    end
    $display("pixel format test done");
    cm = 8'($urandom);
    pay[0] = 8'($urandom);
    bb_sel(1'b0);
    bb_bits(PI_CMD_WR, 8);
    bb_bits(ADDR_PAD, 8);
    bb_sel(1'b1);
    bb_sel(1'b0);
    bb_bits(cm, 8);
    bb_bits(8'h00, 5);
    bb_sel(1'b1);
    bb_sel(1'b0);
    bb_bits(ADDR_PAD, 8);
    bb_bits(pay[0], 8);
    bb_sel(1'b1);
    repeat (12) @(posedge mclk);
    chk(25'(cq_b.size()), 25'h1);
    chk(25'(cq_b.pop_front()), 25'(cm));
    chk(25'(pq_b.size()), 25'h1);
    chk(25'(pq_b.pop_front()), 25'(pay[0]));
    $display("break and pause test done");
    end_sim();
  end
  // cuts a hang short well past the expected run length
  initial
  begin
    #3000000;
    num_errors++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    end_sim();
  end
endmodule : tb_quad_serial_host_port
`default_nettype wire
